// File: hw/tcc_channel.sv
/*
 * One capture/compare channel: edge-triggered capture of the shared counter,
 * compare match with pin action, and the 16-bit value register.
 * Assumes count changes only in the cycle marked by step.
 */
`timescale 1ns/1ps
module tcc_channel (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  ctrl,
	input  wire logic [15:0] count,
	input  wire logic        step,
	input  wire logic        wrap,
	input  wire logic        pin_in,
	input  wire logic        wr_high,
	input  wire logic        wr_low,
	input  wire logic [7:0]  wdata,
	output logic [15:0]      value,
	output logic             event_pulse,
	output logic             pin_out,
	output logic             pin_oe
);
	logic                 pin_prev;
	logic                 capture;
	logic                 match;
	tcc_pkg::tcc_action_t action;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	assign action = tcc_pkg::tcc_action_t'({ctrl[tcc_pkg::TSC_ELSB], ctrl[tcc_pkg::TSC_ELSA]});

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= pin_in;
		end
	end

	always_comb begin
		capture = !ctrl[tcc_pkg::TSC_MSA] && ((ctrl[tcc_pkg::TSC_ELSA] && pin_in && !pin_prev) ||
			(ctrl[tcc_pkg::TSC_ELSB] && !pin_in && pin_prev));
		match   = ctrl[tcc_pkg::TSC_MSA] && step && (count == value);
	end

	// No reset here: the value holds whatever it had before reset.
	always_ff @(posedge ref_clk) begin
		if (capture) begin
			value <= count;
		end else begin
			if (wr_high) begin
				value[15:8] <= wdata;
			end
			if (wr_low) begin
				value[7:0] <= wdata;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			event_pulse <= 1'b0;
		end else begin
			event_pulse <= capture || match;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
		end else begin
			pin_oe <= ctrl[tcc_pkg::TSC_MSA] && (action != tcc_pkg::TCC_ACT_NONE);
			if (match && !(ctrl[tcc_pkg::TSC_FULL] && ctrl[tcc_pkg::TSC_TOW])) begin
				unique case (action)
					tcc_pkg::TCC_ACT_NONE:   pin_out <= pin_out;
					tcc_pkg::TCC_ACT_TOGGLE: pin_out <= !pin_out;
					tcc_pkg::TCC_ACT_CLEAR:  pin_out <= 1'b0;
					tcc_pkg::TCC_ACT_SET:    pin_out <= 1'b1;
				endcase
			end else if (ctrl[tcc_pkg::TSC_MSA] && wrap && ctrl[tcc_pkg::TSC_TOW]) begin
				pin_out <= !pin_out;
			end
		end
	end

	capture_rise_a: assert property (
		(!ctrl[tcc_pkg::TSC_MSA] && ctrl[tcc_pkg::TSC_ELSA] && pin_in && !pin_prev) |=> (value == $past(count)))
		else $error("capture did not latch the counter");

	compare_event_a: assert property (
		(ctrl[tcc_pkg::TSC_MSA] && step && count == value) |=> event_pulse)
		else $error("compare match gave no event");

	compare_clear_a: assert property (
		(ctrl[tcc_pkg::TSC_MSA] && step && count == value && !ctrl[tcc_pkg::TSC_FULL] &&
		action == tcc_pkg::TCC_ACT_CLEAR) |=> !pin_out)
		else $error("clear on compare failed");

	no_pass_a: assert property (
		(ctrl[tcc_pkg::TSC_MSA] && !step) |=> !event_pulse)
		else $error("compare event without counter step");

	direct_write_a: assert property (
		(ctrl[tcc_pkg::TSC_MSA] && wr_low && !wr_high) |=> (value[7:0] == $past(wdata) && $stable(value[15:8])))
		else $error("compare value not written directly");

endmodule : tcc_channel

// File: hw/tcc_channels_top.sv
/*
 * Timer with two capture/compare channels behind an APB slave: the shared
 * 16-bit counter, its prescaler, register file and a masked interrupt.
 * Assumes the APB master and pins are synchronous to ref_clk.
 */
`timescale 1ns/1ps
module tcc_channels_top (
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [tcc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      external_timer_clock_pin,
	input  wire logic                      ch4_pin_in,
	output logic                           ch4_pin_out,
	output logic                           ch4_pin_oe,
	input  wire logic                      ch5_pin_in,
	output logic                           ch5_pin_out,
	output logic                           ch5_pin_oe,
	output logic                           irq
);
	logic [2:0]  clock_prescale_select;
	logic        stop;
	logic        ovie;
	logic        tick;
	logic [15:0] count;
	logic [15:0] modulo;
	logic        step;
	logic        wrap;
	logic [7:0]  ch_ctrl [2];
	logic [15:0] ch_value [2];
	logic [1:0]  ch_event;
	logic [1:0]  ch_pin_in;
	logic [1:0]  ch_pin_out;
	logic [1:0]  ch_pin_oe;
	logic [1:0]  ch_wr_high;
	logic [1:0]  ch_wr_low;
	logic [2:0]  stat;
	logic [2:0]  mask;
	logic [2:0]  enable;
	logic [2:0]  stat_set;
	logic [2:0]  stat_clr;
	logic        setup;
	logic        access;
	logic        wr_en;
	logic        ctrl_clear;
	logic        rd_hit;
	logic [7:0]  rd_byte;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	function automatic logic [7:0] ctrl_view(input logic [7:0] ctrl, input logic flag);
		ctrl_view = (ctrl & tcc_pkg::TSC_WMASK) | {flag, 7'h00};
	endfunction : ctrl_view

	// APB handshake: one wait-free access phase, answer prepared at setup.
	assign setup      = psel && !penable;
	assign access     = psel && penable && pready;
	assign wr_en      = access && pwrite && !pslverr;
	assign ctrl_clear = wr_en && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_TIMER_CTRL) && pwdata[tcc_pkg::CTRL_CLEAR];

	tcc_prescaler u_prescaler (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.sel     (clock_prescale_select),
		.ext_clk (external_timer_clock_pin),
		.tick    (tick)
	);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count <= tcc_pkg::COUNT_RESET;
		end else if (ctrl_clear) begin
			count <= tcc_pkg::COUNT_RESET;
		end else if (tick && !stop) begin
			if (count == modulo) begin
				count <= tcc_pkg::COUNT_RESET;
			end else begin
				count <= count + 16'h0001;
			end
		end
	end

	// Step and wrap mark the cycle in which count shows its new value.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			step <= 1'b0;
			wrap <= 1'b0;
		end else begin
			step <= tick && !stop && !ctrl_clear;
			wrap <= tick && !stop && !ctrl_clear && (count == modulo);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			clock_prescale_select <= tcc_pkg::PS_RESET;
			stop                  <= 1'b0;
			ovie                  <= 1'b0;
		end else if (wr_en && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_TIMER_CTRL)) begin
			clock_prescale_select <= pwdata[2:0];
			stop                  <= pwdata[tcc_pkg::CTRL_STOP];
			ovie                  <= pwdata[tcc_pkg::CTRL_OVIE];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			modulo <= tcc_pkg::MOD_RESET;
		end else if (wr_en) begin
			if (tcc_pkg::is_reg(paddr, tcc_pkg::IDX_MOD_HIGH)) begin
				modulo[15:8] <= pwdata[7:0];
			end
			if (tcc_pkg::is_reg(paddr, tcc_pkg::IDX_MOD_LOW)) begin
				modulo[7:0] <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ch_ctrl[0] <= tcc_pkg::TSC_RESET;
			ch_ctrl[1] <= tcc_pkg::TSC_RESET;
		end else if (wr_en) begin
			if (tcc_pkg::is_reg(paddr, tcc_pkg::IDX_CH4_CTRL)) begin
				ch_ctrl[0] <= pwdata[7:0] & tcc_pkg::TSC_WMASK;
			end
			if (tcc_pkg::is_reg(paddr, tcc_pkg::IDX_CH5_CTRL)) begin
				ch_ctrl[1] <= pwdata[7:0] & tcc_pkg::TSC_WMASK;
			end
		end
	end

	always_comb begin
		ch_wr_high[0] = wr_en && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_CH4_HIGH);
		ch_wr_low[0]  = wr_en && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_CH4_LOW);
		ch_wr_high[1] = wr_en && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_CH5_HIGH);
		ch_wr_low[1]  = wr_en && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_CH5_LOW);
	end

	assign ch_pin_in = {ch5_pin_in, ch4_pin_in};

	// Both channels see the very same counter, step and wrap.
	for (genvar i = 0; i < 2; i++) begin : g_ch
		tcc_channel u_channel (
			.ref_clk     (ref_clk),
			.rst_n       (rst_n),
			.ctrl        (ch_ctrl[i]),
			.count       (count),
			.step        (step),
			.wrap        (wrap),
			.pin_in      (ch_pin_in[i]),
			.wr_high     (ch_wr_high[i]),
			.wr_low      (ch_wr_low[i]),
			.wdata       (pwdata[7:0]),
			.value       (ch_value[i]),
			.event_pulse (ch_event[i]),
			.pin_out     (ch_pin_out[i]),
			.pin_oe      (ch_pin_oe[i])
		);
	end

	assign ch4_pin_out = ch_pin_out[0];
	assign ch4_pin_oe  = ch_pin_oe[0];
	assign ch5_pin_out = ch_pin_out[1];
	assign ch5_pin_oe  = ch_pin_oe[1];

	// Only the bits returned by this read are cleared, so an event landing
	// between setup and access stays pending and the set always wins.
	always_comb begin
		stat_set = {wrap, ch_event};
		stat_clr = 3'h0;
		if (access && !pwrite && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_IRQ_STAT)) begin
			stat_clr = prdata[2:0];
		end
		enable = {ovie, ch_ctrl[1][tcc_pkg::TSC_IE], ch_ctrl[0][tcc_pkg::TSC_IE]};
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stat <= 3'h0;
		end else begin
			stat <= (stat & ~stat_clr) | stat_set;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mask <= tcc_pkg::MASK_RESET;
		end else if (wr_en && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_IRQ_MASK)) begin
			mask <= pwdata[2:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat & mask & enable);
		end
	end

	// The counter read is not latched: a high byte then low byte read can
	// straddle a carry, so software rereads the high byte if it must.
	always_comb begin
		rd_hit  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
		rd_byte = 8'h00;
		unique case (paddr[9:2])
			tcc_pkg::IDX_TIMER_CTRL: rd_byte = {stat[tcc_pkg::STAT_OVF], ovie, stop, 2'b00, clock_prescale_select};
			tcc_pkg::IDX_COUNT_HIGH: rd_byte = count[15:8];
			tcc_pkg::IDX_COUNT_LOW:  rd_byte = count[7:0];
			tcc_pkg::IDX_MOD_HIGH:   rd_byte = modulo[15:8];
			tcc_pkg::IDX_MOD_LOW:    rd_byte = modulo[7:0];
			tcc_pkg::IDX_CH4_CTRL:   rd_byte = ctrl_view(ch_ctrl[0], stat[tcc_pkg::STAT_CH4]);
			tcc_pkg::IDX_CH4_HIGH:   rd_byte = ch_value[0][15:8];
			tcc_pkg::IDX_CH4_LOW:    rd_byte = ch_value[0][7:0];
			tcc_pkg::IDX_CH5_CTRL:   rd_byte = ctrl_view(ch_ctrl[1], stat[tcc_pkg::STAT_CH5]);
			tcc_pkg::IDX_CH5_HIGH:   rd_byte = ch_value[1][15:8];
			tcc_pkg::IDX_CH5_LOW:    rd_byte = ch_value[1][7:0];
			tcc_pkg::IDX_IRQ_STAT:   rd_byte = {5'h00, stat};
			tcc_pkg::IDX_IRQ_MASK:   rd_byte = {5'h00, mask};
			default:                 rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !rd_hit;
			if (setup) begin
				prdata <= {24'h000000, rd_hit ? rd_byte : 8'h00};
			end
		end
	end

	count_step_a: assert property (
		(tick && !stop && !ctrl_clear && count != modulo) |=> (count == $past(count) + 16'h0001))
		else $error("counter did not advance on tick");

	wrap_zero_a: assert property (
		(tick && !stop && !ctrl_clear && count == modulo) |=> (count == 16'h0000) ##1 stat[tcc_pkg::STAT_OVF])
		else $error("wrap missing or no overflow flag");

	irq_raise_a: assert property (
		(ch_event[0] && mask[tcc_pkg::STAT_CH4] && ch_ctrl[0][tcc_pkg::TSC_IE] &&
		$stable(mask) && !wr_en) |-> ##2 irq)
		else $error("enabled channel event gave no interrupt");

	set_wins_a: assert property (
		(ch_event[1] && stat_clr[tcc_pkg::STAT_CH5]) |=> stat[tcc_pkg::STAT_CH5])
		else $error("flag lost under read clear");

	// Every setup is answered at the next edge, for one cycle only.
	setup_ready_a: assert property (
		setup |=> pready)
		else $error("setup not answered");

	ready_pulse_a: assert property (
		pready |=> !pready)
		else $error("ready held past one cycle");

	// A refused address must not leak a register byte onto the bus.
	unmapped_err_a: assert property (
		(setup && !rd_hit) |=>
		(pslverr && prdata == 32'h00000000))
		else $error("refused access not flagged cleanly");

	count_read_a: assert property (
		(setup && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_COUNT_LOW)) |=>
		(prdata[7:0] == $past(count[7:0])))
		else $error("count read not taken at setup");

	// Stop freezes the count; clear zeroes it and must not look like a wrap.
	stop_hold_a: assert property (
		(stop && !ctrl_clear) |=> $stable(count))
		else $error("stopped counter moved");

	clear_zero_a: assert property (
		ctrl_clear |=>
		(count == tcc_pkg::COUNT_RESET && !step && !wrap))
		else $error("counter clear misbehaved");

	// Register writes take effect at the access edge.
	sel_write_a: assert property (
		(wr_en && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_TIMER_CTRL)) |=>
		(clock_prescale_select == $past(pwdata[2:0])))
		else $error("prescale select not written");

	modulo_write_a: assert property (
		(wr_en && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_MOD_LOW)) |=>
		(modulo[7:0] == $past(pwdata[7:0])))
		else $error("modulo low byte not written");

	ctrl_write_a: assert property (
		(wr_en && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_CH4_CTRL)) |=>
		(ch_ctrl[0] == ($past(pwdata[7:0]) & tcc_pkg::TSC_WMASK)))
		else $error("channel control not written");

	mask_write_a: assert property (
		(wr_en && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_IRQ_MASK)) |=>
		(mask == $past(pwdata[2:0])))
		else $error("interrupt mask not written");

	// Read clear drops exactly the bits returned, unless a new event sets them.
	stat_clear_a: assert property (
		(access && !pwrite && tcc_pkg::is_reg(paddr, tcc_pkg::IDX_IRQ_STAT) &&
		stat_set == 3'h0) |=> ((stat & $past(prdata[2:0])) == 3'h0))
		else $error("status read did not clear");

	// The interrupt follows masked, enabled status one cycle late.
	ch4_irq_a: assert property (
		(stat[tcc_pkg::STAT_CH4] && mask[tcc_pkg::STAT_CH4] && ch_ctrl[0][tcc_pkg::TSC_IE]) |=>
		irq)
		else $error("channel interrupt not raised");

	ovf_irq_a: assert property (
		(stat[tcc_pkg::STAT_OVF] && mask[tcc_pkg::STAT_OVF] && ovie) |=>
		irq)
		else $error("overflow interrupt not raised");

	irq_quiet_a: assert property (
		((stat & mask & enable) == 3'h0) |=> !irq)
		else $error("interrupt without enabled source");

endmodule : tcc_channels_top

// File: hw/tcc_pkg.sv
/*
 * Shared constants for the timer capture/compare channel block: register
 * indices, field positions, reset values and the compare pin actions.
 * Assumes a 32-bit APB where each register index occupies one aligned word.
 */
package tcc_pkg;

	localparam int unsigned ADDR_W = 12;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_TIMER_CTRL = 8'h20;
	localparam logic [7:0] IDX_COUNT_HIGH = 8'h21;
	localparam logic [7:0] IDX_COUNT_LOW  = 8'h22;
	localparam logic [7:0] IDX_MOD_HIGH   = 8'h23;
	localparam logic [7:0] IDX_MOD_LOW    = 8'h24;
	localparam logic [7:0] IDX_CH4_CTRL   = 8'h32;
	localparam logic [7:0] IDX_CH4_HIGH   = 8'h33;
	localparam logic [7:0] IDX_CH4_LOW    = 8'h34;
	localparam logic [7:0] IDX_CH5_CTRL   = 8'h35;
	localparam logic [7:0] IDX_CH5_HIGH   = 8'h36;
	localparam logic [7:0] IDX_CH5_LOW    = 8'h37;
	localparam logic [7:0] IDX_IRQ_STAT   = 8'h38;
	localparam logic [7:0] IDX_IRQ_MASK   = 8'h39;

	// Channel status and control fields.
	localparam int unsigned TSC_FLAG = 7;
	localparam int unsigned TSC_IE   = 6;
	localparam int unsigned TSC_MSA  = 4;
	localparam int unsigned TSC_ELSB = 3;
	localparam int unsigned TSC_ELSA = 2;
	localparam int unsigned TSC_TOW  = 1;
	localparam int unsigned TSC_FULL = 0;
	localparam logic [7:0]  TSC_WMASK = 8'h5F;
	localparam logic [7:0]  TSC_RESET = 8'h00;

	// Timer control fields.
	localparam int unsigned CTRL_CLEAR = 4;
	localparam int unsigned CTRL_STOP  = 5;
	localparam int unsigned CTRL_OVIE  = 6;
	localparam int unsigned CTRL_OVF   = 7;
	localparam logic [2:0]  PS_RESET   = 3'h0;
	localparam logic [2:0]  PS_EXT     = 3'h7;

	// Interrupt status and mask bit positions.
	localparam int unsigned STAT_CH4 = 0;
	localparam int unsigned STAT_CH5 = 1;
	localparam int unsigned STAT_OVF = 2;
	localparam logic [2:0]  MASK_RESET = 3'h0;

	localparam logic [15:0] MOD_RESET   = 16'hFFFF;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	// Compare pin action, coded as the two edge-level select bits.
	typedef enum logic [1:0] {
		TCC_ACT_NONE,
		TCC_ACT_TOGGLE,
		TCC_ACT_CLEAR,
		TCC_ACT_SET
	} tcc_action_t;

	function automatic logic is_reg(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		is_reg = (addr == {2'b00, idx, 2'b00});
	endfunction : is_reg

endpackage : tcc_pkg

// File: hw/tcc_prescaler.sv
/*
 * Timer clock prescaler: a one-cycle tick at one of seven divided rates of
 * ref_clk or on each rising edge of the external timer clock pin.
 * Assumes the external pin is already synchronous to ref_clk.
 */
`timescale 1ns/1ps
module tcc_prescaler (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] sel,
	input  wire logic       ext_clk,
	output logic            tick
);
	logic [5:0] div;
	logic [5:0] span;
	logic       ext_prev;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			div <= 6'h00;
		end else begin
			div <= div + 6'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ext_prev <= 1'b0;
		end else begin
			ext_prev <= ext_clk;
		end
	end

	always_comb begin
		span = (6'h01 << sel) - 6'h01;
		if (sel == tcc_pkg::PS_EXT) begin
			tick = ext_clk && !ext_prev;
		end else begin
			tick = (div & span) == span;
		end
	end

	undivided_tick_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sel == 3'h0) |-> tick) else $error("undivided tick missing");

	half_rate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sel == 3'h1 && $stable(sel) && tick) |=> (!tick || sel != 3'h1)) else $error("half rate ticks twice");

endmodule : tcc_prescaler

// File: test/tb_top.sv
/*
 * Self-checking bench for the timer capture/compare block: APB register
 * access, prescaler, capture, compare and interrupts.
 * Assumes zero-wait APB answers and the pin partner model beside the design.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("mismatch t=%0t g=%h e=%h", $time, g, e); end end
module tb_top;
	logic                        ref_clk = 1'b0;
	logic                        rst_n = 1'b0;
	logic                        psel = 1'b0;
	logic                        penable = 1'b0;
	logic                        pwrite = 1'b0;
	logic [tcc_pkg::ADDR_W-1:0]  paddr = 12'h000;
	logic [31:0]                 pwdata = 32'h00000000;
	logic [31:0]                 prdata;
	logic                        pready;
	logic                        pslverr;
	logic                        ext_clk;
	logic [1:0]                  pin_in;
	logic [1:0]                  pin_out;
	logic [1:0]                  pin_oe;
	logic                        irq;
	int                          mismatches = 0;
	int                          n_tests = 0;
	int                          cycles = 0;
	logic [31:0]                 rd;
	logic                        err;
	logic [15:0]                 c;
	logic [15:0]                 v;

	always #5 ref_clk = ~ref_clk;

	tcc_channels_top tcc_channels_top_inst (
		.ref_clk                  (ref_clk),
		.rst_n                    (rst_n),
		.psel                     (psel),
		.penable                  (penable),
		.pwrite                   (pwrite),
		.paddr                    (paddr),
		.pwdata                   (pwdata),
		.prdata                   (prdata),
		.pready                   (pready),
		.pslverr                  (pslverr),
		.external_timer_clock_pin (ext_clk),
		.ch4_pin_in               (pin_in[0]),
		.ch4_pin_out              (pin_out[0]),
		.ch4_pin_oe               (pin_oe[0]),
		.ch5_pin_in               (pin_in[1]),
		.ch5_pin_out              (pin_out[1]),
		.ch5_pin_oe               (pin_oe[1]),
		.irq                      (irq)
	);

	tcc_pin_partner partner (
		.ref_clk (ref_clk),
		.pin_out (pin_out),
		.pin_oe  (pin_oe),
		.pin_in  (pin_in),
		.ext_clk (ext_clk)
	);

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_sim();
		end
	end

	task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] wd);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= {24'h000000, wd};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr16(input logic [7:0] idx, input logic [15:0] val);
		apb(idx, 1'b1, val[15:8]);
		apb(idx + 8'h01, 1'b1, val[7:0]);
	endtask : wr16

	task automatic rd16(input logic [7:0] idx, output logic [15:0] val);
		apb(idx, 1'b0, 8'h00);
		val[15:8] = rd[7:0];
		apb(idx + 8'h01, 1'b0, 8'h00);
		val[7:0] = rd[7:0];
	endtask : rd16

	function automatic logic [7:0] hi_idx(input int ch);
		return (ch == 0) ? tcc_pkg::IDX_CH4_HIGH : tcc_pkg::IDX_CH5_HIGH;
	endfunction : hi_idx

	function automatic logic cap_exp(input int m, input logic rising);
		return (m == 3) || (m == 1 && rising) || (m == 2 && !rising);
	endfunction : cap_exp

	task automatic test_regs();
		logic [15:0] val;
		for (int i = 0; i < 8; i++) begin
			val = 16'($urandom);
			wr16(hi_idx(i % 2), val);
			rd16(hi_idx(i % 2), v);
			`CHK(v, val)
		end
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd16(tcc_pkg::IDX_CH5_HIGH, v);
		`CHK(v, val)
		apb(tcc_pkg::IDX_CH5_CTRL, 1'b0, 8'h00);
		`CHK(rd[7:0], tcc_pkg::TSC_RESET)
		apb(tcc_pkg::IDX_IRQ_MASK, 1'b0, 8'h00);
		`CHK(rd[2:0], tcc_pkg::MASK_RESET)
		rd16(tcc_pkg::IDX_MOD_HIGH, v);
		`CHK(v, tcc_pkg::MOD_RESET)
		apb(8'h3F, 1'b0, 8'h00);
		`CHK({err, rd}, {1'b1, 32'h00000000})
		$display("test regs done");
	endtask : test_regs

	task automatic test_prescale();
		int n;
		for (int s = 0; s < 7; s++) begin
			apb(tcc_pkg::IDX_TIMER_CTRL, 1'b1, 8'h10 | 8'(s));
			repeat (128) @(posedge ref_clk);
			// Three more cycles pass before the stop write lands.
			apb(tcc_pkg::IDX_TIMER_CTRL, 1'b1, 8'h20 | 8'(s));
			rd16(tcc_pkg::IDX_COUNT_HIGH, c);
			`CHK(c >= 16'((131 >> s) - 2) && c <= 16'((131 >> s) + 2), 1'b1)
		end
		n = $urandom_range(3, 10);
		apb(tcc_pkg::IDX_TIMER_CTRL, 1'b1, 8'h17);
		partner.ext_burst(n);
		repeat (4) @(posedge ref_clk);
		apb(tcc_pkg::IDX_TIMER_CTRL, 1'b1, 8'h27);
		rd16(tcc_pkg::IDX_COUNT_HIGH, c);
		`CHK(c, 16'(n))
		$display("test prescale done");
	endtask : test_prescale

	task automatic test_capture();
		logic [15:0] c2;
		apb(tcc_pkg::IDX_TIMER_CTRL, 1'b1, 8'h10);
		repeat ($urandom_range(5, 200)) @(posedge ref_clk);
		apb(tcc_pkg::IDX_TIMER_CTRL, 1'b1, 8'h20);
		rd16(tcc_pkg::IDX_COUNT_HIGH, c);
		for (int ch = 0; ch < 2; ch++) begin
			for (int m = 0; m < 4; m++) begin
				apb(hi_idx(ch) - 8'h01, 1'b1, 8'(m << 2));
				for (int e = 0; e < 2; e++) begin
					wr16(hi_idx(ch), ~c);
					partner.toggle(ch);
					repeat (6) @(posedge ref_clk);
					rd16(hi_idx(ch), v);
					`CHK(v, cap_exp(m, e == 0) ? c : ~c)
				end
			end
		end
		apb(tcc_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
		`CHK(rd[1:0], 2'b11)
		apb(tcc_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
		`CHK(rd[1:0], 2'b00)
		apb(tcc_pkg::IDX_TIMER_CTRL, 1'b1, 8'h00);
		repeat ($urandom_range(5, 50)) @(posedge ref_clk);
		apb(tcc_pkg::IDX_TIMER_CTRL, 1'b1, 8'h20);
		rd16(tcc_pkg::IDX_COUNT_HIGH, c2);
		apb(tcc_pkg::IDX_CH4_CTRL, 1'b1, 8'h4C);
		apb(tcc_pkg::IDX_CH5_CTRL, 1'b1, 8'h04);
		apb(tcc_pkg::IDX_IRQ_MASK, 1'b1, 8'h03);
		partner.toggle(0);
		repeat (6) @(posedge ref_clk);
		`CHK(irq, 1'b1)
		rd16(tcc_pkg::IDX_CH4_HIGH, v);
		`CHK(v, c2)
		apb(tcc_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
		`CHK(rd[0], 1'b1)
		repeat (3) @(posedge ref_clk);
		`CHK(irq, 1'b0)
		partner.toggle(1);
		partner.toggle(1);
		repeat (6) @(posedge ref_clk);
		`CHK(irq, 1'b0)
		apb(tcc_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
		`CHK(rd[1], 1'b1)
		$display("test capture done");
	endtask : test_capture

	task automatic test_compare();
		logic       p0;
		logic [1:0] act;
		apb(tcc_pkg::IDX_MOD_HIGH, 1'b1, 8'h00);
		apb(tcc_pkg::IDX_MOD_LOW, 1'b1, 8'h10);
		apb(tcc_pkg::IDX_IRQ_MASK, 1'b1, 8'h05);
		for (int k = 0; k < 6; k++) begin
			act = 2'(k % 3 + 1);
			// The counter is held while the compare value moves, so no match is lost or doubled.
			apb(tcc_pkg::IDX_TIMER_CTRL, 1'b1, 8'h20);
			wr16(tcc_pkg::IDX_CH4_HIGH, 16'($urandom_range(1, 15)));
			apb(tcc_pkg::IDX_CH4_CTRL, 1'b1, {4'h5, act, 2'b00});
			apb(tcc_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
			apb(tcc_pkg::IDX_TIMER_CTRL, 1'b1, 8'h50);
			repeat (40) @(posedge ref_clk);
			`CHK(pin_oe, 2'b01)
			`CHK(irq, 1'b1)
			if (act == 2'b01) begin
				p0 = pin_out[0];
				repeat (17) @(posedge ref_clk);
				`CHK(pin_out[0], ~p0)
			end else begin
				`CHK(pin_out, {1'b0, act[0]})
			end
			apb(tcc_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
			`CHK({rd[2], rd[0]}, 2'b11)
		end
		apb(tcc_pkg::IDX_TIMER_CTRL, 1'b1, 8'h20);
		rd16(tcc_pkg::IDX_COUNT_HIGH, c);
		wr16(tcc_pkg::IDX_CH4_HIGH, c);
		apb(tcc_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
		repeat (20) @(posedge ref_clk);
		apb(tcc_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
		`CHK(rd[0], 1'b0)
		$display("test compare done");
	endtask : test_compare

	initial begin
		void'($urandom(19084));
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		test_regs();
		test_prescale();
		test_capture();
		test_compare();
		end_sim();
	end
endmodule : tb_top

// File: test/tcc_pin_partner.sv
/*
 * Behavioural model of the signals outside the timer pins: two channel pin
 * sources and the external timer clock source.
 * Assumes the bench calls its tasks right after a rising edge of ref_clk.
 */
`timescale 1ns/1ps
module tcc_pin_partner (
	input  wire logic       ref_clk,
	input  wire logic [1:0] pin_out,
	input  wire logic [1:0] pin_oe,
	output logic [1:0]      pin_in,
	output logic            ext_clk
);
	logic [1:0] level;

	initial begin
		level = 2'b00;
		ext_clk = 1'b0;
	end

	// A pin that the channel drives reads back the channel's own level.
	assign pin_in[0] = pin_oe[0] ? pin_out[0] : level[0];
	assign pin_in[1] = pin_oe[1] ? pin_out[1] : level[1];

	task automatic toggle(input int ch);
		@(posedge ref_clk);
		level[ch] <= ~level[ch];
	endtask : toggle

	// Slow enough that every edge is seen by the synchronous pin logic.
	task automatic ext_burst(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			ext_clk <= 1'b1;
			repeat (2) @(posedge ref_clk);
			ext_clk <= 1'b0;
			@(posedge ref_clk);
		end
	endtask : ext_burst
endmodule : tcc_pin_partner
